// ==== include/rcd_pkg.sv ====
// Purpose: shared constants and types for the core decode and mode block
// Assumes: 16-bit instruction words, 8-bit data path
// Notes: opcode patterns are matched against the upper instruction bits; sleep, trap and the table subcode also use lower bits
package rcd_pkg;
  localparam logic [7:0] OP_RRF_HI = 8'h1d;
  localparam logic [7:0] OP_SUBR_HI = 8'h1f;
  localparam logic [7:0] OP_XORR_HI = 8'h1e;
  localparam logic [7:0] OP_SUBL_HI = 8'h0d;
  localparam logic [7:0] OP_XORL_HI = 8'h0b;
  localparam logic [7:0] OP_SKZ_HI = 8'h20;
  localparam logic [7:0] OP_TBL_HI = 8'h2f;
  localparam logic [1:0] OP_TBL_SUB = 2'h1;
  localparam logic [15:0] OP_SLEEP = 16'h0202;
  localparam logic [15:0] OP_TRAP = 16'h0000;
  localparam logic [2:0] OP_GOTO_HI = 3'h2;
  localparam logic [2:0] OP_CALL_HI = 3'h3;
  localparam int IND_BIT = 7;
  localparam int DST_BIT = 6;
  localparam int SUPPLY_HOLD_POS = 6;
  localparam logic [7:0] FRONTEND_CFG_RST = 8'h00;
  localparam logic [7:0] EE_BASE_HI = 8'he8;

  typedef enum logic [1:0] {
    RCD_RESET = 2'b00,
    RCD_EXEC = 2'b01,
    RCD_SLEEP = 2'b11,
    RCD_SHUTDOWN = 2'b10
  } rcd_mode_t;

  typedef struct packed {
    logic [5:0] faddr;
    logic indirect;
    logic dest_f;
    logic [7:0] literal;
    logic [7:0] long_addr;
    logic [2:0] bitnum;
    logic [12:0] jump_target;
  } rcd_fields_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } rcd_flags_t;
endpackage : rcd_pkg

// ==== src/rcd_field_split.sv ====
// Purpose: split an instruction word into its operand fields
// Assumes: combinational, same clock domain
// Notes: pure wiring of fields, no state
`timescale 1ns/1ps
module rcd_field_split (
  input wire logic [15:0] i_instr,
  output rcd_pkg::rcd_fields_t o_fields
);
  // operand field extraction
  always_comb begin
    o_fields.faddr = i_instr[5:0]; // RULE10
    o_fields.indirect = i_instr[rcd_pkg::IND_BIT]; // RULE10
    o_fields.dest_f = i_instr[rcd_pkg::DST_BIT]; // RULE9
    o_fields.literal = i_instr[7:0]; // RULE14
    o_fields.long_addr = i_instr[13:6]; // RULE11
    o_fields.bitnum = i_instr[8:6]; // RULE12
    o_fields.jump_target = i_instr[12:0]; // RULE13
  end
endmodule : rcd_field_split

// ==== src/rcd_alu.sv ====
// Purpose: arithmetic unit for subtract, exclusive-or and rotate right
// Assumes: operands are settled when sampled by the caller
// Notes: carry after subtract means no borrow
`timescale 1ns/1ps
module rcd_alu (
  input wire logic [1:0] i_sel,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_carry,
  output logic [7:0] o_res,
  output rcd_pkg::rcd_flags_t o_flags
);
  logic [8:0] diff;
  logic [4:0] ndiff;
  // sel 0 subtract a-b, 1 xor, 2 rotate a right through carry
  always_comb begin
    diff = {1'b0, i_a} + {1'b0, ~i_b} + 9'h001;
    ndiff = {1'b0, i_a[3:0]} + {1'b0, ~i_b[3:0]} + 5'h01;
    o_flags.c = i_carry;
    o_flags.dc = 1'b0;
    o_res = 8'h00;
    unique case (i_sel)
      2'h0: begin
        o_res = diff[7:0]; // RULE4
        o_flags.c = diff[8]; // RULE4
        o_flags.dc = ndiff[4]; // RULE4
      end
      2'h1: o_res = i_a ^ i_b; // RULE6
      2'h2: begin
        o_res = {i_carry, i_a[7:1]}; // RULE1
        o_flags.c = i_a[0]; // RULE1
      end
      default: o_res = i_a;
    endcase
    o_flags.z = (o_res == 8'h00);
  end
endmodule : rcd_alu

// ==== src/rcd_core_decode.sv ====
// What this block does
// (RULE1) rotate right through carry, only carry changes, one or two cycles
// (RULE2) skip next instruction when operand is zero, flags unchanged
// (RULE3) sleep opcode stops execution until a wake event
// (RULE4) subtracts f minus w and w minus literal set c, dc, z
// (RULE5) all-zero opcode raises a software trap interrupt in one cycle
// (RULE6) xor with literal or register updates only zero flag
// (RULE7) table read loads w from program word at base and register value
// (RULE8) branching paths take the larger cycle count
// (RULE9) destination bit one writes register, zero writes w
// (RULE10) six-bit direct address, indirect form uses stored byte as address
// (RULE11) long register field reaches the whole eight-bit data space
// (RULE12) bit field picks bits zero to seven, seven is msb
// (RULE13) jump and call take a thirteen-bit target
// (RULE14) literal field is an eight-bit constant
// (RULE15) operand reads from data eeprom add one cycle; here ST_EXTRA and a second operand cycle add two
// (RULE16) modes are shutdown, sleep, master clear and execution
// (RULE17) oscillator may run in sleep during eeprom write or bus mastering
// (RULE18) oscillator turns on when sleep ends
// (RULE19) sleep ends on master clear, watchdog or any enabled interrupt
// (RULE20) master clear low resets logic, floats ports, turns gate drives off
// (RULE21) master clear release starts execution
// (RULE22) software clears supply hold bit to allow shutdown
//
// Purpose: decode and execute part of the core instruction set plus mode control
// Assumes: data memory answers reads in the next cycle, program memory in the same cycle as the request
// Notes: master clear pin is synchronised; reset input is the system reset
`timescale 1ns/1ps
module rcd_core_decode (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_master_clear_n,
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic [7:0] i_w,
  input wire logic i_carry,
  input wire logic [7:0] i_dmem_rdata,
  input wire logic [15:0] i_pmem_rdata,
  input wire logic [7:0] i_table_base_reg,
  input wire logic i_irq_pending,
  input wire logic i_watchdog_timeout,
  input wire logic i_ee_write_busy,
  input wire logic i_bus_master_active,
  input wire logic i_pack_supply_present,
  input wire logic [7:0] i_frontend_config_reg,
  output logic o_busy,
  output logic [7:0] o_dmem_addr,
  output logic o_dmem_rd,
  output logic o_dmem_we,
  output logic [7:0] o_dmem_wdata,
  output logic [15:0] o_pmem_addr,
  output logic o_pmem_rd,
  output logic [7:0] o_w_next,
  output logic o_w_we,
  output rcd_pkg::rcd_flags_t o_flags,
  output logic [2:0] o_flags_we,
  output logic o_skip_next,
  output logic o_pc_load,
  output logic [12:0] o_pc_target,
  output logic o_jump_is_call,
  output logic o_trap_irq,
  output logic [2:0] o_bitnum,
  output logic [7:0] o_long_addr,
  output rcd_pkg::rcd_mode_t o_mode,
  output logic o_osc_en,
  output logic o_core_reset,
  output logic [7:0] o_general_port_pins_oe_n,
  output logic [7:0] o_high_voltage_port_pins_oe_n,
  output logic o_discharge_gate_drive,
  output logic o_charge_gate_drive
);
  typedef enum logic [2:0] {
    ST_DECODE = 3'b000,
    ST_IND = 3'b001,
    ST_OPER = 3'b011,
    ST_EXTRA = 3'b010,
    ST_SKIPW = 3'b110
  } rcd_state_t;

  rcd_pkg::rcd_fields_t fld;
  rcd_pkg::rcd_flags_t alu_flags;
  logic [7:0] alu_res;
  logic [1:0] alu_sel;
  logic master_clear_n_meta_reg;
  logic master_clear_n_sync_reg;
  rcd_pkg::rcd_mode_t mode_reg;
  rcd_pkg::rcd_mode_t mode_next;
  rcd_state_t state_reg;
  rcd_state_t state_next;
  logic [15:0] ir_reg;
  logic [7:0] oper_addr_reg;
  logic [7:0] oper_reg;
  logic [7:0] oper_val;
  logic ee_wait_reg;
  logic [15:0] hi_ir;
  logic is_rrf;
  logic is_subr;
  logic is_xorr;
  logic is_skz;
  logic is_tbl;
  logic is_regop;
  logic ee_addr;
  logic core_rst;

  rcd_field_split u_split (
    .i_instr(ir_reg),
    .o_fields(fld)
  );

  rcd_alu u_alu (
    .i_sel(alu_sel),
    .i_a(is_subr ? oper_val : (alu_sel == 2'h2 ? oper_val : i_w)),
    .i_b(is_subr ? i_w : (is_xorr ? oper_val : fld.literal)),
    .i_carry(i_carry),
    .o_res(alu_res),
    .o_flags(alu_flags)
  );

  // two-stage synchroniser on the master clear pin
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      master_clear_n_meta_reg <= 1'b0;
      master_clear_n_sync_reg <= 1'b0;
    end else begin
      master_clear_n_meta_reg <= i_master_clear_n;
      master_clear_n_sync_reg <= master_clear_n_meta_reg;
    end
  end

  assign core_rst = !i_rst_n || !master_clear_n_sync_reg; // RULE20

  // opcode classification on the held instruction
  always_comb begin
    hi_ir = ir_reg;
    is_rrf = hi_ir[15:8] == rcd_pkg::OP_RRF_HI;
    is_subr = hi_ir[15:8] == rcd_pkg::OP_SUBR_HI;
    is_xorr = hi_ir[15:8] == rcd_pkg::OP_XORR_HI;
    is_skz = hi_ir[15:8] == rcd_pkg::OP_SKZ_HI;
    is_tbl = hi_ir[15:8] == rcd_pkg::OP_TBL_HI && hi_ir[7:6] == rcd_pkg::OP_TBL_SUB;
    is_regop = is_rrf || is_subr || is_xorr || is_skz;
    alu_sel = is_rrf ? 2'h2 : ((is_xorr || hi_ir[15:8] == rcd_pkg::OP_XORL_HI) ? 2'h1 : 2'h0);
    ee_addr = oper_addr_reg >= rcd_pkg::EE_BASE_HI;
  end

  // operand source: read data stands only in the cycle after the request,
  // so the first operand cycle takes it directly; after an eeprom wait the
  // copy captured on the first pass is used, as the memory need not hold it
  always_comb begin
    oper_val = (state_reg == ST_OPER && !ee_wait_reg) ? i_dmem_rdata : oper_reg; // RULE10 RULE15
  end

  // operating mode: reset, execute, sleep, shutdown
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      rcd_pkg::RCD_RESET: mode_next = rcd_pkg::RCD_EXEC; // RULE21
      rcd_pkg::RCD_EXEC: begin
        if (state_reg == ST_DECODE && i_instr_valid && i_instr == rcd_pkg::OP_SLEEP)
          mode_next = rcd_pkg::RCD_SLEEP; // RULE3
        if (!i_frontend_config_reg[rcd_pkg::SUPPLY_HOLD_POS] && !i_pack_supply_present)
          mode_next = rcd_pkg::RCD_SHUTDOWN; // RULE22
      end
      rcd_pkg::RCD_SLEEP: begin
        if (i_irq_pending || i_watchdog_timeout)
          mode_next = rcd_pkg::RCD_EXEC; // RULE19
      end
      rcd_pkg::RCD_SHUTDOWN: begin
        if (i_pack_supply_present)
          mode_next = rcd_pkg::RCD_EXEC;
      end
    endcase
  end

  // mode register, master clear forces reset mode
  always_ff @(posedge i_mclk) begin
    if (core_rst) mode_reg <= rcd_pkg::RCD_RESET; // RULE16
    else mode_reg <= mode_next;
  end

  // execution sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_DECODE: begin
        if (mode_reg == rcd_pkg::RCD_EXEC && i_instr_valid) begin
          // literal forms have no memory operand but share the operand cycle,
          // and their bit 7 belongs to the constant, never an indirect flag
          if (i_instr[15:8] == rcd_pkg::OP_TBL_HI || i_instr[15:8] == rcd_pkg::OP_SUBL_HI
              || i_instr[15:8] == rcd_pkg::OP_XORL_HI
              || i_instr[15:14] == 2'h0 && i_instr[13:12] != 2'h0)
            state_next = i_instr[rcd_pkg::IND_BIT] && i_instr[15:12] != 4'h0
              && i_instr[15:8] != rcd_pkg::OP_TBL_HI ? ST_IND : ST_OPER; // RULE10
        end
      end
      ST_IND: state_next = ST_OPER; // RULE10
      ST_OPER: state_next = (ee_addr && !ee_wait_reg) ? ST_EXTRA : ST_DECODE;
      ST_EXTRA: state_next = ST_OPER; // RULE15
      ST_SKIPW: state_next = ST_DECODE; // RULE8
      default: state_next = ST_DECODE;
    endcase
    if (state_reg == ST_OPER && state_next == ST_DECODE && (is_skz && oper_val == 8'h00 || is_tbl))
      state_next = ST_SKIPW; // RULE2 RULE7 RULE8
  end

  // sequence state, held instruction and operand
  always_ff @(posedge i_mclk) begin
    if (core_rst) begin
      state_reg <= ST_DECODE;
      ir_reg <= 16'h0000;
      oper_addr_reg <= 8'h00;
      oper_reg <= 8'h00;
      ee_wait_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // words offered in sleep or shutdown are ignored, fields stay as they were
      if (state_reg == ST_DECODE && i_instr_valid && mode_reg == rcd_pkg::RCD_EXEC) begin
        ir_reg <= i_instr;
        oper_addr_reg <= {2'h0, i_instr[5:0]}; // RULE10
        ee_wait_reg <= 1'b0;
      end
      if (state_reg == ST_IND) oper_addr_reg <= i_dmem_rdata; // RULE10
      if (state_reg == ST_EXTRA) ee_wait_reg <= 1'b1; // RULE15
      if (state_reg == ST_OPER && !ee_wait_reg) oper_reg <= i_dmem_rdata; // RULE15
    end
  end

  // memory requests
  always_comb begin
    o_dmem_rd = state_reg == ST_DECODE && i_instr_valid || state_reg == ST_IND;
    // indirect cycle: the pointer just read is the operand address
    o_dmem_addr = state_reg == ST_DECODE ? {2'h0, i_instr[5:0]}
      : (state_reg == ST_IND ? i_dmem_rdata : oper_addr_reg); // RULE10
    o_pmem_rd = state_reg == ST_SKIPW && is_tbl; // RULE7
    o_pmem_addr = {i_table_base_reg, oper_reg}; // RULE7
  end

  // result routing and flag updates, registered
  always_ff @(posedge i_mclk) begin
    if (core_rst) begin
      o_w_next <= 8'h00;
      o_w_we <= 1'b0;
      o_dmem_we <= 1'b0;
      o_dmem_wdata <= 8'h00;
      o_flags <= '0;
      o_flags_we <= 3'h0;
      o_skip_next <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc_target <= 13'h0000;
      o_jump_is_call <= 1'b0;
      o_trap_irq <= 1'b0;
    end else begin
      o_w_we <= 1'b0;
      o_dmem_we <= 1'b0;
      o_flags_we <= 3'h0;
      o_skip_next <= 1'b0;
      o_pc_load <= 1'b0;
      o_trap_irq <= 1'b0;
      o_flags <= alu_flags;
      if (state_reg == ST_DECODE && i_instr_valid && mode_reg == rcd_pkg::RCD_EXEC) begin
        o_trap_irq <= i_instr == rcd_pkg::OP_TRAP; // RULE5
        if (i_instr[15:14] == 2'h1) begin
          o_pc_load <= 1'b1;
          o_pc_target <= i_instr[12:0]; // RULE13
          o_jump_is_call <= i_instr[15:13] == rcd_pkg::OP_CALL_HI;
        end
      end
      if (state_reg == ST_SKIPW && is_tbl) begin
        o_w_next <= i_pmem_rdata[7:0]; // RULE7
        o_w_we <= 1'b1;
      end
      if (state_reg == ST_OPER && state_next != ST_EXTRA) begin
        if (is_skz) o_skip_next <= oper_val == 8'h00; // RULE2
        if (hi_ir[15:8] == rcd_pkg::OP_SUBL_HI || hi_ir[15:8] == rcd_pkg::OP_XORL_HI) begin
          o_w_next <= alu_res; // RULE14
          o_w_we <= 1'b1;
          o_flags_we <= hi_ir[15:8] == rcd_pkg::OP_SUBL_HI ? 3'h7 : 3'h1; // RULE4 RULE6
        end else if (is_regop && !is_skz) begin
          o_flags_we <= is_rrf ? 3'h4 : (is_subr ? 3'h7 : 3'h1); // RULE1 RULE4 RULE6
          o_dmem_wdata <= alu_res;
          o_dmem_we <= fld.dest_f; // RULE9
          o_w_next <= alu_res;
          o_w_we <= !fld.dest_f; // RULE9
        end
      end
    end
  end

  // pin state, oscillator and status outputs
  always_comb begin
    o_mode = mode_reg;
    o_busy = state_reg != ST_DECODE || mode_reg != rcd_pkg::RCD_EXEC;
    o_core_reset = core_rst;
    o_osc_en = mode_reg != rcd_pkg::RCD_SLEEP || i_ee_write_busy || i_bus_master_active
      || mode_next == rcd_pkg::RCD_EXEC; // RULE17 RULE18
    o_general_port_pins_oe_n = 8'hff; // RULE20
    o_high_voltage_port_pins_oe_n = 8'hff; // RULE20
    o_discharge_gate_drive = !core_rst; // RULE20
    o_charge_gate_drive = !core_rst; // RULE20
    o_bitnum = fld.bitnum; // RULE12
    o_long_addr = fld.long_addr; // RULE11
  end
endmodule : rcd_core_decode

// ==== testbench/rcd_core_decode_props.sv ====
// Purpose: concurrent checks on the decode and mode ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the decode block
`timescale 1ns/1ps
module rcd_core_decode_props (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_master_clear_n,
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic i_irq_pending,
  input wire logic i_watchdog_timeout,
  input wire logic o_busy,
  input wire logic [2:0] o_flags_we,
  input wire logic o_trap_irq,
  input wire logic [2:0] o_bitnum,
  input wire logic [7:0] o_long_addr,
  input wire rcd_pkg::rcd_mode_t o_mode,
  input wire logic o_osc_en,
  input wire logic o_core_reset,
  input wire logic o_discharge_gate_drive,
  input wire logic o_charge_gate_drive
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic take;
  logic [15:0] last_instr;
  // word accepted at this edge
  assign take = i_instr_valid && !o_busy;
  // copy of the last accepted word
  always_ff @(posedge i_mclk) begin
    if (take) begin
      last_instr <= i_instr;
    end
  end
  a_field_split: assert property (
    take |=> o_long_addr == last_instr[13:6] && o_bitnum == last_instr[8:6])
    else $error("field outputs differ from accepted word");
  a_trap_pulse: assert property (
    take && i_instr == rcd_pkg::OP_TRAP |-> ##[1:4] o_trap_irq)
    else $error("trap word gave no trap pulse");
  a_sleep_entry: assert property (
    take && i_instr == rcd_pkg::OP_SLEEP |-> ##[1:3] o_mode == rcd_pkg::RCD_SLEEP)
    else $error("sleep word did not enter sleep");
  a_table_two: assert property (
    take && i_instr[15:8] == rcd_pkg::OP_TBL_HI |=> o_busy)
    else $error("table read finished in one cycle");
  a_xor_zero: assert property (
    take && (i_instr[15:8] == rcd_pkg::OP_XORL_HI || i_instr[15:8] == rcd_pkg::OP_XORR_HI)
    |-> ##[1:6] o_flags_we == 3'b001)
    else $error("xor did not write zero flag alone");
  a_wake_exit: assert property (
    o_mode == rcd_pkg::RCD_SLEEP && (i_irq_pending || i_watchdog_timeout)
    |-> ##[1:4] o_mode == rcd_pkg::RCD_EXEC)
    else $error("wake source did not end sleep");
  a_osc_run: assert property (
    o_mode == rcd_pkg::RCD_EXEC |-> o_osc_en)
    else $error("oscillator off while executing");
  a_master_clear_n_hold: assert property (
    !i_master_clear_n [*4] |-> o_core_reset && o_mode == rcd_pkg::RCD_RESET
    && !o_discharge_gate_drive && !o_charge_gate_drive)
    else $error("master clear low did not hold reset");
  a_master_clear_n_free: assert property (
    $rose(i_master_clear_n) |-> ##[1:6] o_mode == rcd_pkg::RCD_EXEC)
    else $error("master clear release did not start execution");
endmodule : rcd_core_decode_props

bind rcd_core_decode rcd_core_decode_props u_props (.i_mclk, .i_rst_n, .i_master_clear_n,
  .i_instr, .i_instr_valid, .i_irq_pending, .i_watchdog_timeout, .o_busy, .o_flags_we,
  .o_trap_irq, .o_bitnum, .o_long_addr, .o_mode, .o_osc_en, .o_core_reset,
  .o_discharge_gate_drive, .o_charge_gate_drive);

// ==== testbench/rcd_core_decode_tb.sv ====
// Purpose: self-checking bench for the decode and mode block
// Assumes: data memory answers one cycle after the read address
// Notes: driver queues expected results, monitor pops them on each pulse
`timescale 1ns/1ps
module rcd_core_decode_tb;
  logic i_mclk, i_rst_n, i_master_clear_n, i_instr_valid, i_carry, i_irq_pending;
  logic i_watchdog_timeout, i_ee_write_busy, i_bus_master_active, i_pack_supply_present;
  logic [15:0] i_instr, i_pmem_rdata, o_pmem_addr, ins, x;
  logic [7:0] i_w, i_dmem_rdata, i_table_base_reg, i_frontend_config_reg, o_dmem_addr;
  logic [7:0] o_dmem_wdata, o_w_next, o_long_addr, w0;
  logic [7:0] o_general_port_pins_oe_n, o_high_voltage_port_pins_oe_n;
  logic o_busy, o_dmem_rd, o_dmem_we, o_pmem_rd, o_w_we, o_skip_next, o_pc_load;
  logic o_jump_is_call, o_trap_irq, o_osc_en, o_core_reset;
  logic o_discharge_gate_drive, o_charge_gate_drive;
  logic [2:0] o_flags_we, o_bitnum;
  logic [12:0] o_pc_target;
  rcd_pkg::rcd_flags_t o_flags;
  rcd_pkg::rcd_mode_t o_mode;
  logic [7:0] mem [256];
  logic [15:0] burst [8];
  logic [40:0] exp_q [$];
  logic [40:0] mon_seen;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;

  rcd_core_decode u_rcd_core_decode (.i_mclk, .i_rst_n, .i_master_clear_n, .i_instr,
    .i_instr_valid, .i_w, .i_carry, .i_dmem_rdata, .i_pmem_rdata, .i_table_base_reg,
    .i_irq_pending, .i_watchdog_timeout, .i_ee_write_busy, .i_bus_master_active,
    .i_pack_supply_present, .i_frontend_config_reg, .o_busy, .o_dmem_addr, .o_dmem_rd,
    .o_dmem_we, .o_dmem_wdata, .o_pmem_addr, .o_pmem_rd, .o_w_next, .o_w_we, .o_flags,
    .o_flags_we, .o_skip_next, .o_pc_load, .o_pc_target, .o_jump_is_call, .o_trap_irq,
    .o_bitnum, .o_long_addr, .o_mode, .o_osc_en, .o_core_reset, .o_general_port_pins_oe_n,
    .o_high_voltage_port_pins_oe_n, .o_discharge_gate_drive, .o_charge_gate_drive);

  // clock
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // memories: data answers next cycle, program word is a fixed function of its address
  always @(posedge i_mclk) i_dmem_rdata <= mem[o_dmem_addr];
  assign i_pmem_rdata = {o_pmem_addr[7:0] ^ 8'h96, o_pmem_addr[15:8] + o_pmem_addr[7:0]};

  task automatic final_report;
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [40:0] seen, input logic [40:0] want);
    n_tests++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, want);
    end
  endtask : chk

  // hang guard
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      final_report();
    end
  end

  // monitor: every result pulse is matched against the oldest note
  always @(negedge i_mclk) begin
    if (i_rst_n && (o_w_we || o_dmem_we || o_skip_next || o_trap_irq || o_pc_load)) begin
      mon_seen = {o_w_we, o_w_we ? o_w_next : 8'h00, o_dmem_we, o_dmem_we ? o_dmem_wdata : 8'h00,
        o_flags_we, o_flags & o_flags_we, o_skip_next, o_trap_irq, o_pc_load,
        o_pc_load ? o_pc_target : 13'h0000, o_pc_load & o_jump_is_call};
      if (exp_q.size() == 0) chk(mon_seen, 41'h0);
      else chk(mon_seen, exp_q.pop_front());
    end
  end

  // notes the expected result, then offers the word until it is taken
  task automatic issue(input logic [15:0] wd, input logic [7:0] w, input logic cy);
    logic [7:0] a, v, r;
    logic [2:0] fl, fwe;
    logic wr, sk, pl, dst;
    int n;
    a = wd[7] ? mem[wd[5:0]] : {2'b00, wd[5:0]};
    v = mem[a];
    {r, fl, fwe, wr, sk, pl} = {8'h00, 6'h00, 3'b100};
    case (wd[15:8])
      rcd_pkg::OP_RRF_HI: {r, fl, fwe} = {cy, v[7:1], v[0], 5'b00100};
      rcd_pkg::OP_SUBR_HI: {r, fwe} = {v - w, 3'b111};
      rcd_pkg::OP_XORR_HI: {r, fwe} = {v ^ w, 3'b001};
      rcd_pkg::OP_SUBL_HI: {r, fwe} = {w - wd[7:0], 3'b111};
      rcd_pkg::OP_XORL_HI: {r, fwe} = {w ^ wd[7:0], 3'b001};
      rcd_pkg::OP_SKZ_HI: {wr, sk} = {1'b0, v == 8'h00};
      rcd_pkg::OP_TBL_HI: r = i_table_base_reg + v;
      default: {wr, pl} = {1'b0, wd[15:14] == 2'b01};
    endcase
    if (wd[15:8] == rcd_pkg::OP_SUBR_HI) fl = {v >= w, v[3:0] >= w[3:0], r == 8'h00};
    if (wd[15:8] == rcd_pkg::OP_SUBL_HI) fl = {w >= wd[7:0], w[3:0] >= wd[3:0], r == 8'h00};
    if (fwe == 3'b001) fl = {2'b00, r == 8'h00};
    dst = wr && wd[12] && wd[6];
    if (wr || sk || pl || wd == rcd_pkg::OP_TRAP)
      exp_q.push_back({wr && !dst, (wr && !dst) ? r : 8'h00, dst, dst ? r : 8'h00, fwe,
        fl & fwe, sk, wd == rcd_pkg::OP_TRAP, pl, pl ? wd[12:0] : 13'h0000, pl && wd[13]});
    i_instr = wd;
    i_w = w;
    i_carry = cy;
    i_instr_valid = 1'b1;
    for (n = 0; n < 40 && o_busy !== 1'b0; n++) @(negedge i_mclk);
    @(negedge i_mclk);
  endtask : issue

  task automatic idle(input int k);
    i_instr_valid = 1'b0;
    repeat (k) @(negedge i_mclk);
  endtask : idle

  // main sequence
  initial begin
    {i_rst_n, i_instr_valid, i_carry, i_irq_pending, i_watchdog_timeout} = 5'h00;
    {i_ee_write_busy, i_bus_master_active, i_master_clear_n, i_pack_supply_present} = 4'h3;
    {i_instr, i_w, i_table_base_reg} = 32'h0;
    void'($urandom(32'ha644cbba));
    i_frontend_config_reg = 8'($urandom) | 8'h40;
    foreach (mem[j]) mem[j] = 8'($urandom);
    mem[5] = 8'h00;
    mem[6] = 8'h05;
    repeat (6) @(negedge i_mclk);
    i_rst_n = 1'b1;
    for (int n = 0; n < 20 && o_mode !== rcd_pkg::RCD_EXEC; n++) @(negedge i_mclk);
    // every opcode kind except sleep, with random operands, direct and indirect
    for (int k = 0; k < 90; k++) begin
      x = 16'($urandom);
      i_table_base_reg = 8'($urandom);
      case (k % 9)
        0: ins = {rcd_pkg::OP_RRF_HI, x[7:0]};
        1: ins = {rcd_pkg::OP_SUBR_HI, x[7:0]};
        2: ins = {rcd_pkg::OP_XORR_HI, x[7:0]};
        3: ins = {rcd_pkg::OP_SUBL_HI, x[7:0]};
        4: ins = {rcd_pkg::OP_XORL_HI, x[7:0]};
        5: ins = {rcd_pkg::OP_SKZ_HI, x[7], 1'b0, x[5:0]};
        6: ins = {rcd_pkg::OP_TBL_HI, 2'b01, x[5:0]};
        7: ins = rcd_pkg::OP_TRAP;
        default: ins = {2'b01, x[13:0]};
      endcase
      issue(ins, x[15:8], x[14]);
      idle(5);
    end
    // back to back words, taken skips, zero result
    w0 = 8'($urandom);
    burst = '{{rcd_pkg::OP_RRF_HI, 8'h86}, {rcd_pkg::OP_SKZ_HI, 8'h05},
      {rcd_pkg::OP_SKZ_HI, 8'h86}, {rcd_pkg::OP_TBL_HI, 8'h45}, rcd_pkg::OP_TRAP,
      16'h7abc, {rcd_pkg::OP_XORL_HI, 8'h5a}, {rcd_pkg::OP_XORL_HI, w0}};
    foreach (burst[j]) issue(burst[j], w0, 1'b1);
    idle(6);
    // sleep, ignored word, oscillator hold, wake by each source
    for (int s = 0; s < 3; s++) begin
      issue(rcd_pkg::OP_SLEEP, 8'h00, 1'b0);
      idle(4);
      chk(41'(o_mode), 41'(rcd_pkg::RCD_SLEEP));
      i_instr = {rcd_pkg::OP_XORL_HI, 8'h11};
      i_instr_valid = 1'b1;
      i_ee_write_busy = (s == 1);
      i_bus_master_active = (s == 2);
      repeat (3) @(negedge i_mclk);
      if (s != 0) chk(41'(o_osc_en), 41'h1);
      {i_instr_valid, i_ee_write_busy, i_bus_master_active} = 3'h0;
      i_irq_pending = (s == 0);
      i_watchdog_timeout = (s == 1);
      i_master_clear_n = (s != 2);
      repeat (6) @(negedge i_mclk);
      if (s == 2) begin
        chk(41'({o_core_reset, o_discharge_gate_drive, o_charge_gate_drive,
          o_general_port_pins_oe_n, o_high_voltage_port_pins_oe_n}), 41'h4ffff);
        i_master_clear_n = 1'b1;
        repeat (6) @(negedge i_mclk);
      end
      chk(41'(o_mode), 41'(rcd_pkg::RCD_EXEC));
      chk(41'(o_osc_en), 41'h1);
      {i_irq_pending, i_watchdog_timeout} = 2'h0;
    end
    // shutdown only when the hold bit is clear and the pack supply is gone
    i_pack_supply_present = 1'b0;
    repeat (6) @(negedge i_mclk);
    chk(41'(o_mode), 41'(rcd_pkg::RCD_EXEC));
    i_frontend_config_reg[rcd_pkg::SUPPLY_HOLD_POS] = 1'b0;
    repeat (6) @(negedge i_mclk);
    chk(41'(o_mode), 41'(rcd_pkg::RCD_SHUTDOWN));
    chk(41'(exp_q.size()), 41'h0);
    final_report();
  end
endmodule : rcd_core_decode_tb
